// [hdl/sfp_pin_if.sv]
/*
 * Pin-level front end of a serial flash: select, sampling and driving edges,
 * lane widening, status write gating, shared pin roles, pause and clear.
 * Assumes an instruction decoder on SYS_CLK_I sets widths and drive direction,
 * and that those levels, the status bits and the transmit byte change only
 * while chip select is high or one byte time ahead of use on the link.
 */
// What this block does
// - Chip select high deselects the device and floats every output.
// - Instructions count only after a chip select fall following a clear; power-up arms on the first clock.
// - Data line bits are discarded while chip select is high.
// - Single-line mode samples instruction, address and data on line 0 rising.
// - Single-line mode drives read data on line 1 from falling edges.
// - Dual and quad lines are bidirectional: rising samples, falling drives.
// - Quad transfers use the protect pin as line 2, shared pin as line 3.
// - Guard set and protect pin low rejects status writes; pin high accepts.
// - Guard clear lets status writes through whatever the protect pin does.
// - Quad enable set stops protection; the protect pin is only line 2.
// - Quad enable set removes pause and shared-pin clear; dedicated clear still works; shared pin is line 3.
// - Without dedicated clear, role select picks pause (0) or clear (1).
// - Dedicated clear enabled makes the shared pin pause regardless of role.
// - Dedicated clear disabled lets role select pick pause or clear again.
// - Pause low suspends the link while selected, keeping sequence progress.
// - Pause and select both low float the output; pause high resumes.
// - Hardware clear low holds reset with outputs floating; high runs.
// - Function register bit 0 set disables the dedicated clear pin.
// - Idle-low and idle-high clock modes both latch rising, drive falling.
`include "sfp_map.svh"
`default_nettype none

module sfp_pin_if #(
	parameter bit HAS_DEDICATED_CLEAR = 1'b1
) (
	input  wire logic                     SYS_CLK_I,
	input  wire logic                     RESET_N_I,
	input  wire logic                     SCK_I,
	input  wire logic                     CS_N_I,
	input  wire logic [3:0]               DL_I,
	output logic      [3:0]               DL_O,
	output logic      [3:0]               DL_OE_O,
	input  wire logic                     CLEAR_N_I,
	input  wire sfp_pkg::sfp_width_type   INSTR_WIDTH_I,
	input  wire sfp_pkg::sfp_width_type   BODY_WIDTH_I,
	input  wire logic                     BODY_DRIVE_I,
	input  wire logic                     PIN_ROLE_SELECT_I,
	input  wire logic [7:0]               FUNCTION_REG_I,
	input  wire logic                     STATUS_WR_I,
	input  wire logic [`SFP_ST_WIDTH-1:0] STATUS_WR_DATA_I,
	output logic      [`SFP_ST_WIDTH-1:0] STATUS_O,
	output logic                          STATUS_WR_REJECT_O,
	output logic      [7:0]               RX_DATA_O,
	output logic                          RX_VALID_O,
	output logic                          RX_INSTR_O,
	input  wire logic                     TX_LOAD_I,
	input  wire logic [7:0]               TX_DATA_I,
	output logic                          TX_REQ_O,
	output logic                          SELECTED_O,
	output logic                          FRAME_END_O,
	output logic                          PAUSED_O,
	output logic                          DEVICE_CLEAR_O
);

	function automatic logic [3:0] lane_count(input sfp_pkg::sfp_width_type w);
		case (w)
			sfp_pkg::SFP_DUAL: lane_count = `SFP_LANE_DUAL;
			sfp_pkg::SFP_QUAD: lane_count = `SFP_LANE_QUAD;
			default:           lane_count = `SFP_LANE_SINGLE;
		endcase
	endfunction : lane_count

	// MSB first; in dual the higher bit rides line 1
	function automatic logic [7:0] shift_in(input logic [7:0] sh,
			input sfp_pkg::sfp_width_type w, input logic [3:0] dl);
		case (w)
			sfp_pkg::SFP_DUAL: shift_in = {sh[5:0], dl[1:0]};
			sfp_pkg::SFP_QUAD: shift_in = {sh[3:0], dl[3:0]};
			default:           shift_in = {sh[6:0], dl[0]};
		endcase
	endfunction : shift_in

	function automatic logic [3:0] lane_out(input logic [7:0] b,
			input sfp_pkg::sfp_width_type w);
		case (w)
			sfp_pkg::SFP_DUAL: lane_out = {2'h0, b[7:6]};
			sfp_pkg::SFP_QUAD: lane_out = b[7:4];
			default:           lane_out = {2'h0, b[7], 1'h0};
		endcase
	endfunction : lane_out

	function automatic logic [3:0] lane_mask(input sfp_pkg::sfp_width_type w);
		case (w)
			sfp_pkg::SFP_DUAL: lane_mask = 4'h3;
			sfp_pkg::SFP_QUAD: lane_mask = 4'hF;
			default:           lane_mask = 4'h2;
		endcase
	endfunction : lane_mask

	// ---------------- Shared pin roles ----------------
	logic [`SFP_ST_WIDTH-1:0] status_q;
	logic                     quad_en;
	logic                     ded_clear_en;
	logic                     shared_is_clear;
	logic                     shared_is_pause;
	logic                     clear_raw;
	logic                     pause_act;

	assign quad_en         = status_q[`SFP_ST_QUAD_BIT];
	assign ded_clear_en    = HAS_DEDICATED_CLEAR
		&& !FUNCTION_REG_I[`SFP_FR_CLEAR_OFF_BIT];
	// Role select only matters with no active dedicated clear
	assign shared_is_clear = !quad_en && !ded_clear_en && PIN_ROLE_SELECT_I;
	assign shared_is_pause = !quad_en && !shared_is_clear;
	assign clear_raw       = (ded_clear_en && !CLEAR_N_I)
		|| (shared_is_clear && !DL_I[`SFP_DL_SHARED]);
	assign pause_act       = shared_is_pause && !DL_I[`SFP_DL_SHARED] && !CS_N_I;

	// ---------------- System domain ----------------
	logic [3:0] pins_s;
	logic       cs_n_s;
	logic       protect_s;
	logic       shared_s;
	logic       dclear_n_s;
	logic       cs_n_last_q;
	logic       armed_q;
	logic       clear_s;

	sfp_sync #(
		.WIDTH     (4),
		.RESET_VAL (32'h0000_000F)
	) u_pin_sync (
		.clk_i     (SYS_CLK_I),
		.reset_n_i (RESET_N_I),
		.async_i   ({CLEAR_N_I, DL_I[`SFP_DL_SHARED], DL_I[`SFP_DL_PROTECT], CS_N_I}),
		.sync_o    (pins_s)
	);

	assign cs_n_s     = pins_s[0];
	assign protect_s  = pins_s[1];
	assign shared_s   = pins_s[2];
	assign dclear_n_s = pins_s[3];
	assign clear_s    = (ded_clear_en && !dclear_n_s) || (shared_is_clear && !shared_s);

	// Armed once synced chip select reads high; it resets high, so only after a clear does a frame need a fall
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			armed_q <= 1'b0;
		end else if (clear_s) begin
			armed_q <= 1'b0;
		end else if (cs_n_s) begin
			armed_q <= 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			cs_n_last_q    <= 1'b1;
			SELECTED_O     <= 1'b0;
			FRAME_END_O    <= 1'b0;
			PAUSED_O       <= 1'b0;
			DEVICE_CLEAR_O <= 1'b0;
		end else begin
			cs_n_last_q    <= cs_n_s;
			SELECTED_O     <= !cs_n_s && armed_q;
			FRAME_END_O    <= cs_n_s && !cs_n_last_q && armed_q;
			PAUSED_O       <= shared_is_pause && !shared_s && !cs_n_s;
			DEVICE_CLEAR_O <= clear_s;
		end
	end

	// Status write gate; protect pin is ignored once quad is on
	logic wr_allowed;

	assign wr_allowed = !status_q[`SFP_ST_GUARD_BIT]
		|| quad_en
		|| protect_s;

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			status_q           <= `SFP_ST_RESET;
			STATUS_WR_REJECT_O <= 1'b0;
		end else begin
			STATUS_WR_REJECT_O <= STATUS_WR_I && !wr_allowed;
			if (STATUS_WR_I && wr_allowed) begin
				status_q <= STATUS_WR_DATA_I;
			end
		end
	end

	assign STATUS_O = status_q;

	// ---------------- Link domain (SCK_I) ----------------
	// Held in reset outside a frame: chip select high, clear, or not armed
	logic link_rst_n;

	assign link_rst_n = RESET_N_I && !CS_N_I && armed_q && !clear_raw;

	sfp_pkg::sfp_phase_type phase_q;
	sfp_pkg::sfp_width_type width_q;
	sfp_pkg::sfp_width_type cur_w;
	logic [3:0]             bit_cnt_q;
	logic [3:0]             cnt_next;
	logic [7:0]             rx_sh_q;
	logic [7:0]             rx_next;
	logic [7:0]             rx_hold_q;
	logic                   rx_instr_q;
	logic                   rx_tog_q;
	logic                   drive_q;

	assign cur_w    = (phase_q == sfp_pkg::SFP_ST_INSTR) ? INSTR_WIDTH_I : width_q;
	assign cnt_next = bit_cnt_q + lane_count(cur_w);
	assign rx_next  = shift_in(rx_sh_q, cur_w, DL_I);

	// Rising edge sampling holds for either clock idle level
	always_ff @(posedge SCK_I or negedge link_rst_n) begin
		if (!link_rst_n) begin
			phase_q   <= sfp_pkg::SFP_ST_INSTR;
			width_q   <= sfp_pkg::SFP_SINGLE;
			bit_cnt_q <= 4'h0;
			rx_sh_q   <= 8'h00;
			drive_q   <= 1'b0;
		end else if (!pause_act) begin
			if (!drive_q) begin
				rx_sh_q <= rx_next;
			end
			if (cnt_next == `SFP_BYTE_BITS) begin
				bit_cnt_q <= 4'h0;
				phase_q   <= sfp_pkg::SFP_ST_BODY;
				width_q   <= BODY_WIDTH_I;
				drive_q   <= BODY_DRIVE_I;
			end else begin
				bit_cnt_q <= cnt_next;
			end
		end
	end

	// Received bytes survive the frame so the system side can still fetch them
	always_ff @(posedge SCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rx_hold_q  <= 8'h00;
			rx_instr_q <= 1'b0;
			rx_tog_q   <= 1'b0;
		end else if (link_rst_n && !pause_act && !drive_q
				&& cnt_next == `SFP_BYTE_BITS) begin
			rx_hold_q  <= rx_next;
			rx_instr_q <= (phase_q == sfp_pkg::SFP_ST_INSTR);
			rx_tog_q   <= !rx_tog_q;
		end
	end

	// Output side changes on falling edges
	logic [7:0] tx_q;
	logic [7:0] out_sh_q;
	logic [3:0] out_q;
	logic       out_valid_q;
	logic       tx_tog_link_q;

	always_ff @(negedge SCK_I or negedge link_rst_n) begin
		if (!link_rst_n) begin
			out_sh_q    <= 8'h00;
			out_q       <= 4'h0;
			out_valid_q <= 1'b0;
		end else if (drive_q && !pause_act) begin
			if (bit_cnt_q == 4'h0) begin
				out_q       <= lane_out(tx_q, width_q);
				out_sh_q    <= tx_q << lane_count(width_q);
				out_valid_q <= 1'b1;
			end else begin
				out_q    <= lane_out(out_sh_q, width_q);
				out_sh_q <= out_sh_q << lane_count(width_q);
			end
		end
	end

	// Byte-taken event survives link reset so the toggle never glitches
	always_ff @(negedge SCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			tx_tog_link_q <= 1'b0;
		end else if (link_rst_n && drive_q && !pause_act && bit_cnt_q == 4'h0) begin
			tx_tog_link_q <= !tx_tog_link_q;
		end
	end

	// Outputs float when deselected, paused or cleared
	assign DL_O    = out_q;
	assign DL_OE_O = (drive_q && out_valid_q && link_rst_n && !pause_act)
		? lane_mask(width_q) : 4'h0;

	// ---------------- Crossings back to the system clock ----------------
	logic rx_evt;
	logic tx_evt;

	sfp_toggle_sync u_rx_evt (
		.clk_i     (SYS_CLK_I),
		.reset_n_i (RESET_N_I),
		.toggle_i  (rx_tog_q),
		.pulse_o   (rx_evt)
	);

	sfp_toggle_sync u_tx_evt (
		.clk_i     (SYS_CLK_I),
		.reset_n_i (RESET_N_I),
		.toggle_i  (tx_tog_link_q),
		.pulse_o   (tx_evt)
	);

	// Hold byte is stable for a whole byte time after its toggle
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			RX_DATA_O  <= 8'h00;
			RX_VALID_O <= 1'b0;
			RX_INSTR_O <= 1'b0;
		end else begin
			RX_VALID_O <= rx_evt;
			if (rx_evt) begin
				RX_DATA_O  <= rx_hold_q;
				RX_INSTR_O <= rx_instr_q;
			end
		end
	end

	// One byte of prefetch; the link reads tx_q a byte after requesting it
	// Crosses as a quasi-static word: read only at a byte boundary,
	// so no handshake back is needed
	// A load too close to that boundary may tear the byte
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			tx_q     <= 8'h00;
			TX_REQ_O <= 1'b0;
		end else begin
			TX_REQ_O <= tx_evt;
			if (TX_LOAD_I) begin
				tx_q <= TX_DATA_I;
			end
		end
	end

endmodule : sfp_pin_if

`default_nettype wire

// [hdl/sfp_map.svh]
/*
 * Bit positions and reset values for the serial flash pin block.
 * Assumes it is included by bare name before any module that uses it.
 */
`ifndef SFP_MAP_SVH
`define SFP_MAP_SVH

// Status field, six protected bits
`define SFP_ST_WIDTH        6
`define SFP_ST_GUARD_BIT    5
`define SFP_ST_QUAD_BIT     4
`define SFP_ST_BP_MSB       3
`define SFP_ST_BP_LSB       0
`define SFP_ST_RESET        6'h00

// Function register bit that turns off the dedicated clear pin
`define SFP_FR_CLEAR_OFF_BIT 0

// Pin positions on the four data lines
`define SFP_DL_PROTECT      2
`define SFP_DL_SHARED       3

`define SFP_BYTE_BITS       4'h8
`define SFP_LANE_SINGLE     4'h1
`define SFP_LANE_DUAL       4'h2
`define SFP_LANE_QUAD       4'h4

`endif

// [hdl/sfp_pkg.sv]
/*
 * Types shared by the serial flash pin block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package sfp_pkg;

	typedef enum logic [1:0] {
		SFP_SINGLE = 2'b00,
		SFP_DUAL   = 2'b01,
		SFP_QUAD   = 2'b10
	} sfp_width_type;

	typedef enum logic [0:0] {
		SFP_ST_INSTR = 1'b0,
		SFP_ST_BODY  = 1'b1
	} sfp_phase_type;

endpackage : sfp_pkg

`default_nettype wire

// [hdl/sfp_sync.sv]
/*
 * Two flip-flop level synchroniser, one bit per lane.
 * Assumes the inputs are levels that stay put for several destination clocks.
 */
`default_nettype none

module sfp_sync #(
	parameter int          WIDTH     = 1,
	parameter logic [31:0] RESET_VAL = 32'h0000_0000
) (
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_q <= RESET_VAL[WIDTH-1:0];
			sync_o <= RESET_VAL[WIDTH-1:0];
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end

endmodule : sfp_sync

`default_nettype wire

// [hdl/sfp_toggle_sync.sv]
/*
 * Event crossing: a toggle from another domain becomes a one-cycle pulse.
 * Assumes the source toggles no faster than once per three destination clocks.
 */
`default_nettype none

module sfp_toggle_sync (
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	input  wire logic toggle_i,
	output logic      pulse_o
);

	logic meta_q;
	logic sync_q;
	logic last_q;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= toggle_i;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	// Edge detect reads only the settled stages
	assign pulse_o = sync_q ^ last_q;

endmodule : sfp_toggle_sync

`default_nettype wire

// [verif/sfp_pin_if_assertions.sv]
/* Port checker for sfp_pin_if.
   Assumes it is bound to every sfp_pin_if instance. */
`include "sfp_map.svh"
`default_nettype none

module sfp_pin_if_assertions #(
	parameter bit HAS_DEDICATED_CLEAR = 1'b1
) (
	input wire logic                     SYS_CLK_I,
	input wire logic                     RESET_N_I,
	input wire logic                     CS_N_I,
	input wire logic [3:0]               DL_I,
	input wire logic [3:0]               DL_OE_O,
	input wire logic                     CLEAR_N_I,
	input wire logic                     PIN_ROLE_SELECT_I,
	input wire logic [7:0]               FUNCTION_REG_I,
	input wire logic                     STATUS_WR_I,
	input wire logic [`SFP_ST_WIDTH-1:0] STATUS_WR_DATA_I,
	input wire logic [`SFP_ST_WIDTH-1:0] STATUS_O,
	input wire logic                     STATUS_WR_REJECT_O,
	input wire logic                     SELECTED_O,
	input wire logic                     PAUSED_O,
	input wire logic                     DEVICE_CLEAR_O
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESET_N_I);
	logic guard;
	logic quad;
	logic ded_on;
	logic sh_on;
	logic pa_on;
	logic free;
	assign guard = STATUS_O[`SFP_ST_GUARD_BIT];
	assign quad = STATUS_O[`SFP_ST_QUAD_BIT];
	assign free = FUNCTION_REG_I[`SFP_FR_CLEAR_OFF_BIT] || !HAS_DEDICATED_CLEAR;
	assign ded_on = HAS_DEDICATED_CLEAR && !FUNCTION_REG_I[0] && !CLEAR_N_I;
	assign sh_on = free && PIN_ROLE_SELECT_I && !quad && !DL_I[`SFP_DL_SHARED];
	assign pa_on = !CS_N_I && !DL_I[`SFP_DL_SHARED] && !quad && (!free || !PIN_ROLE_SELECT_I);
	sequence s_prot_low;
		(!DL_I[`SFP_DL_PROTECT])[*4] ##0 (STATUS_WR_I && guard && !quad);
	endsequence
	sequence s_prot_high;
		(DL_I[`SFP_DL_PROTECT])[*4] ##0 STATUS_WR_I;
	endsequence
	sequence s_taken;
		##1 (STATUS_O == $past(STATUS_WR_DATA_I) && !STATUS_WR_REJECT_O);
	endsequence
	property p_cs_float;
		CS_N_I |-> DL_OE_O == 4'h0;
	endproperty
	property p_clr_float;
		DEVICE_CLEAR_O |-> DL_OE_O == 4'h0;
	endproperty
	property p_oe_shape;
		1'b1 |-> DL_OE_O inside {4'h0, 4'h2, 4'h3, 4'hF};
	endproperty
	property p_wr_reject;
		s_prot_low |=> STATUS_WR_REJECT_O && $stable(STATUS_O);
	endproperty
	property p_wr_high;
		s_prot_high |-> s_taken;
	endproperty
	property p_wr_open;
		STATUS_WR_I && (!guard || quad) |-> s_taken;
	endproperty
	property p_rej_cause;
		STATUS_WR_REJECT_O |-> $past(STATUS_WR_I && guard && !quad);
	endproperty
	property p_quad_pin;
		quad[*5] |-> !PAUSED_O;
	endproperty
	property p_ded_clr;
		ded_on[*5] |-> DEVICE_CLEAR_O;
	endproperty
	property p_sh_clr;
		sh_on[*5] |-> DEVICE_CLEAR_O;
	endproperty
	property p_no_clr;
		(!ded_on && !sh_on)[*5] |-> !DEVICE_CLEAR_O;
	endproperty
	property p_pause;
		pa_on[*5] |-> PAUSED_O && DL_OE_O == 4'h0;
	endproperty
	property p_desel;
		CS_N_I[*5] |-> !SELECTED_O;
	endproperty
	a_cs_float: assert property (p_cs_float) else $error("drive while deselected");
	a_clr_float: assert property (p_clr_float) else $error("drive during clear");
	a_oe_shape: assert property (p_oe_shape) else $error("bad enable set");
	a_wr_reject: assert property (p_wr_reject) else $error("write not refused");
	a_wr_high: assert property (p_wr_high) else $error("write refused");
	a_wr_open: assert property (p_wr_open) else $error("open write lost");
	a_rej_cause: assert property (p_rej_cause) else $error("stray refusal");
	a_quad_pin: assert property (p_quad_pin) else $error("pause in quad");
	a_ded_clr: assert property (p_ded_clr) else $error("clear pin ignored");
	a_sh_clr: assert property (p_sh_clr) else $error("shared clear ignored");
	a_no_clr: assert property (p_no_clr) else $error("stray clear");
	a_pause: assert property (p_pause) else $error("pause not held");
	a_desel: assert property (p_desel) else $error("still selected");
endmodule : sfp_pin_if_assertions

bind sfp_pin_if sfp_pin_if_assertions #(.HAS_DEDICATED_CLEAR(HAS_DEDICATED_CLEAR)) u_chk (
	.SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I), .CS_N_I(CS_N_I), .DL_I(DL_I),
	.DL_OE_O(DL_OE_O), .CLEAR_N_I(CLEAR_N_I), .PIN_ROLE_SELECT_I(PIN_ROLE_SELECT_I),
	.FUNCTION_REG_I(FUNCTION_REG_I), .STATUS_WR_I(STATUS_WR_I),
	.STATUS_WR_DATA_I(STATUS_WR_DATA_I), .STATUS_O(STATUS_O),
	.STATUS_WR_REJECT_O(STATUS_WR_REJECT_O), .SELECTED_O(SELECTED_O),
	.PAUSED_O(PAUSED_O), .DEVICE_CLEAR_O(DEVICE_CLEAR_O));

`default_nettype wire

// [verif/sfp_host_model.sv]
/* Host end of the serial link: clock, select, data lines.
   Assumes the bench resolves each line from both enables. */
`default_nettype none

module sfp_host_model (
	input  wire logic [3:0] dq_i,
	output logic            sck_o,
	output logic            cs_n_o,
	output logic [3:0]      dq_o,
	output logic [3:0]      dq_oe_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic cpol = 1'b0;
	logic prot = 1'b1;
	logic pause_n = 1'b1;
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		park();
	end
	task automatic park(); // Line 1 left to the device
		dq_o = {pause_n, prot, 2'b00};
		dq_oe_o = 4'hD;
	endtask : park
	task automatic tick(output logic [3:0] q);
		sck_o = 1'b0;
		#7.5;
		sck_o = 1'b1;
		q = dq_i;
		#7.5;
	endtask : tick
	task automatic sel();
		sck_o = cpol;
		#20;
		cs_n_o = 1'b0;
		#20;
	endtask : sel
	task automatic desel();
		sck_o = cpol;
		#20;
		cs_n_o = 1'b1;
		park();
		#200;
	endtask : desel
	task automatic send(input logic [7:0] b, input int w, input int n);
		logic [3:0] q;
		dq_oe_o = (w == 1) ? 4'hD : 4'hF;
		for (int i = 0; i < n; i++) begin
			dq_o = {pause_n, prot, 2'b00};
			if (w == 1) dq_o[0] = b[7];
			else if (w == 2) dq_o[1:0] = b[7:6];
			else dq_o = b[7:4];
			b = b << w;
			tick(q);
		end
		#200; // Byte time must span four system clocks
		park();
	endtask : send
	task automatic recv(input int w, output logic [7:0] r);
		logic [3:0] q;
		dq_oe_o = (w == 1) ? 4'hD : (w == 2) ? 4'hC : 4'h0;
		r = 8'h00;
		for (int i = 0; i < 8 / w; i++) begin
			tick(q);
			r = (w == 1) ? {r[6:0], q[1]} : (w == 2) ? {r[5:0], q[1:0]} : {r[3:0], q};
		end
		#200;
	endtask : recv
endmodule : sfp_host_model

`default_nettype wire

// [verif/sfp_pin_if_tb.sv]
/* Self-checking bench for sfp_pin_if with a host model.
   Assumes design, checker and host model compiled first. */
`default_nettype none

module sfp_pin_if_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic                   sys_clk = 1'b0;
	logic                   reset_n = 1'b0;
	logic                   sck;
	logic                   cs_n;
	logic [3:0]             hdo;
	logic [3:0]             hoe;
	logic [3:0]             dl;
	logic [3:0]             dl_o;
	logic [3:0]             dl_oe;
	logic                   clear_n = 1'b1;
	sfp_pkg::sfp_width_type iw = sfp_pkg::SFP_SINGLE;
	sfp_pkg::sfp_width_type bw = sfp_pkg::SFP_SINGLE;
	logic                   drive = 1'b0;
	logic                   role = 1'b0;
	logic                   wr = 1'b0;
	logic                   tx_ld = 1'b0;
	logic [7:0]             fr = 8'h00;
	logic [7:0]             tx = 8'h00;
	logic [5:0]             wr_d = 6'h00;
	logic [7:0]             rx_d;
	logic [5:0]             st;
	logic                   rej;
	logic                   rx_v;
	logic                   rx_i;
	logic                   paused;
	logic                   dclr;
	logic                   tx_req;
	logic                   selected;
	logic                   frame_end;
	int                     frames = 0;
	int                     reqs = 0;
	int                     err_count = 0;
	int                     checked = 0;
	logic [8:0]             rxq[$];
	sfp_pkg::sfp_width_type wt[3] = '{sfp_pkg::SFP_SINGLE, sfp_pkg::SFP_DUAL, sfp_pkg::SFP_QUAD};
	int                     ln[3] = '{1, 2, 4};
	logic [3:0]             oe_exp[3] = '{4'h2, 4'h3, 4'hF};

	// Undriven lines show the inverse of the last device value
	assign dl = (dl_oe & dl_o) | (~dl_oe & hoe & hdo) | (~dl_oe & ~hoe & ~dl_o);
	always #20 sys_clk = ~sys_clk;
	// Registered outputs are read half a cycle after they settle
	always @(negedge sys_clk) begin
		if (rx_v) rxq.push_back({rx_i, rx_d});
		if (frame_end) frames++;
		if (tx_req) reqs++;
	end

	sfp_host_model host (.dq_i(dl), .sck_o(sck), .cs_n_o(cs_n), .dq_o(hdo), .dq_oe_o(hoe));
	sfp_pin_if dut (.SYS_CLK_I(sys_clk), .RESET_N_I(reset_n), .SCK_I(sck), .CS_N_I(cs_n),
		.DL_I(dl), .DL_O(dl_o), .DL_OE_O(dl_oe), .CLEAR_N_I(clear_n), .INSTR_WIDTH_I(iw),
		.BODY_WIDTH_I(bw), .BODY_DRIVE_I(drive), .PIN_ROLE_SELECT_I(role),
		.FUNCTION_REG_I(fr), .STATUS_WR_I(wr), .STATUS_WR_DATA_I(wr_d), .STATUS_O(st),
		.STATUS_WR_REJECT_O(rej), .RX_DATA_O(rx_d), .RX_VALID_O(rx_v), .RX_INSTR_O(rx_i),
		.TX_LOAD_I(tx_ld), .TX_DATA_I(tx), .TX_REQ_O(tx_req), .SELECTED_O(selected),
		.FRAME_END_O(frame_end), .PAUSED_O(paused), .DEVICE_CLEAR_O(dclr));

	task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	task automatic summarize();
		if (err_count == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : summarize
	task automatic clk(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : clk
	task automatic pins(input logic p, input logic h);
		host.prot = p;
		host.pause_n = h;
		host.park();
		clk(5);
	endtask : pins
	task automatic wr_st(input logic [5:0] v, input logic r, input logic [5:0] e);
		clk(1);
		wr = 1'b1;
		wr_d = v;
		clk(1);
		wr = 1'b0;
		chk("reject", r, rej);
		chk("status", e, st);
	endtask : wr_st
	task automatic load(input logic [7:0] d);
		clk(1);
		drive = 1'b1;
		tx = d;
		tx_ld = 1'b1;
		clk(1);
		tx_ld = 1'b0;
	endtask : load
	task automatic t_rx(input int i);
		clk(1);
		iw = wt[i];
		bw = wt[i];
		drive = 1'b0;
		rxq.delete();
		host.sel();
		host.send(8'hA5, ln[i], 8 / ln[i]);
		host.send(8'h3C, ln[i], 8 / ln[i]);
		host.desel();
		chk("rx count", 9'h002, 9'(rxq.size()));
		chk("rx instr", 9'h1A5, rxq[0]);
		chk("rx body", 9'h03C, rxq[1]);
	endtask : t_rx
	task automatic t_read(input logic m, input int i);
		logic [7:0] r;
		int         f0;
		int         q0;
		clk(1);
		iw = sfp_pkg::SFP_SINGLE;
		bw = wt[i];
		f0 = frames;
		q0 = reqs;
		load({m, 5'h0B, 2'(i)});
		host.cpol = m;
		host.sel();
		host.send(8'h0B, 1, 8);
		host.recv(ln[i], r);
		chk("read oe", oe_exp[i], dl_oe);
		chk("read data", tx, r);
		chk("selected", 9'h001, selected);
		host.desel();
		chk("idle oe", 9'h000, dl_oe);
		chk("frame end", 9'h001, 9'(frames - f0));
		// Idle-low clock falls once more before deselect and takes a second byte
		chk("tx req", 9'(2 - m), 9'(reqs - q0));
	endtask : t_read
	task automatic t_clr(input logic f, input logic p, input logic c, input logic h,
			input logic e);
		clk(1);
		fr = {7'h00, f};
		role = p;
		clear_n = c;
		pins(1'b1, h);
		chk("clear", e, dclr);
		clear_n = 1'b1;
		pins(1'b1, 1'b1);
	endtask : t_clr
	task automatic t_pause();
		logic [7:0] r;
		fr = 8'h00;
		role = 1'b0;
		iw = sfp_pkg::SFP_SINGLE;
		bw = sfp_pkg::SFP_SINGLE;
		load(8'h96);
		rxq.delete();
		host.sel();
		host.send(8'hA5, 1, 4);
		pins(1'b1, 1'b0);
		chk("paused", 9'h001, paused);
		host.send(8'hFF, 1, 2);
		pins(1'b1, 1'b1);
		host.send(8'h50, 1, 4);
		host.recv(1, r);
		chk("pause data", 9'h096, r);
		pins(1'b1, 1'b0);
		chk("pause oe", 9'h000, dl_oe);
		pins(1'b1, 1'b1);
		chk("resume oe", 9'h002, dl_oe);
		host.desel();
		chk("rx instr", 9'h1A5, rxq[0]);
	endtask : t_pause

	initial begin
		clk(8);
		reset_n = 1'b1;
		clk(4);
		host.send(8'hA5, 1, 8);
		chk("rx count", 9'h000, 9'(rxq.size()));
		pins(1'b1, 1'b1);
		wr_st(6'h25, 1'b0, 6'h25);
		pins(1'b0, 1'b1);
		wr_st(6'h0A, 1'b1, 6'h25);
		pins(1'b1, 1'b1);
		wr_st(6'h30, 1'b0, 6'h30);
		pins(1'b0, 1'b1);
		wr_st(6'h13, 1'b0, 6'h13);
		wr_st(6'h10, 1'b0, 6'h10);
		pins(1'b1, 1'b1);
		for (int i = 0; i < 3; i++) t_rx(i);
		for (int m = 0; m < 2; m++)
			for (int i = 0; i < 3; i++) t_read(m[0], i);
		t_clr(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
		wr_st(6'h00, 1'b0, 6'h00);
		t_clr(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
		t_clr(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		t_clr(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
		t_clr(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
		t_pause();
		summarize();
	end
	initial begin
		#2000000;
		err_count++;
		summarize();
	end
endmodule : sfp_pin_if_tb

`default_nettype wire
